/* common/pbsp_defs.svh */
// Constants for the pipelined burst SRAM port
`ifndef PBSP_DEFS_SVH
`define PBSP_DEFS_SVH

// Default geometry: 512K words of four byte lanes, each with parity
`define PBSP_ADDR_W     19
`define PBSP_LANES      4
`define PBSP_BYTE_W     8
`define PBSP_LANE_W     9

// Burst counter field inside the address
`define PBSP_BURST_LSB  0
`define PBSP_BURST_W    2
`define PBSP_BEAT_RST   2'h0
`define PBSP_BEAT_STEP  2'h1

// Reset values of the filtered pins and of control state
`define PBSP_SYNC_RST   3'h0
`define PBSP_OE_SYNC_RST 3'h7
`define PBSP_OE_RST     1'h1
`define PBSP_SLEEP_RST  1'h0
`define PBSP_MODE_SYNC_RST 3'h7
`define PBSP_MODE_RST   1'h1
`define PBSP_SEL_RST    1'h0

`endif

/* common/pbsp_pkg.sv */
// Types shared by the pipelined burst SRAM port
package pbsp_pkg;

  // Synchronous bus controls, all sampled on the rising clock edge
  typedef struct packed {
    logic processorAddrStrobeN;
    logic controllerAddrStrobeN;
    logic burstAdvanceN;
    logic globalWriteN;
    logic byteWriteEnableN;
    logic chipSelectPrimaryN;
    logic chipSelectExpandHi;
    logic chipSelectExpandN;
  } pbsp_ctrl_t;

  // Kind of array access held in the first pipeline stage
  typedef enum logic [1:0] {
    PBSP_ACC_IDLE  = 2'b00,
    PBSP_ACC_READ  = 2'b01,
    PBSP_ACC_WRITE = 2'b10
  } pbsp_acc_t;

endpackage

/* hw/pbsp_sram_port.sv */
// Device-side logic of a pipelined burst SRAM with burst counter
`timescale 1ns/1ns
`include "pbsp_defs.svh"

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Capture address on strobe with chip selected
// - Low two address bits feed burst counter
// - Lane written when lane select and enable low
// - Global write writes every lane, ignoring selects
// - Advance low increments burst counter in burst
// - Selected only when enables low, high, low
// - Processor strobe ignored while primary select high
// - Chip enables judged only on address loads
// - Output enable low drives pins, high releases
// - First read beat after deselect stays released
// - Advance steps burst address every asserted cycle while selected and awake, unless a strobe loads
// - Accepted strobe loads address and burst counter
// - Processor strobe wins when both strobes low
// - Sleep input holds device idle, data kept
// - Write data and parity registered on edge
// - Read data one cycle after address edge
// - Strap low linear, high or open interleaved
// - Two-bit wrapping counter from first address
module pbsp_sram_port
  import pbsp_pkg::*;
#(
  parameter int ADDR_W = `PBSP_ADDR_W,
  parameter int LANES  = `PBSP_LANES
)(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Synchronous bus controls and address
  input  wire pbsp_ctrl_t                 busCtrl,
  input  wire logic [ADDR_W-1:0]          address,
  input  wire logic [LANES-1:0]           byteLaneSelectN,
  // Asynchronous pins and burst order strap
  input  wire logic                       outputEnableN,
  input  wire logic                       sleepRequest,
  input  wire logic                       burstOrderMode,
  // Data pins, split into input, output and enable
  input  wire logic [LANES*8-1:0]         dataIn,
  input  wire logic [LANES-1:0]           parityLanesIn,
  output logic      [LANES*8-1:0]         dataOut,
  output logic      [LANES-1:0]           parityLanesOut,
  output logic                            dataOe
);

  localparam int DATA_W = LANES * `PBSP_BYTE_W;
  localparam int WORD_W = LANES * `PBSP_LANE_W;
  localparam int BW     = `PBSP_BURST_W;

  typedef struct packed {
    logic [2:0]            oeSync;
    logic [2:0]            sleepSync;
    logic [2:0]            modeSync;
    logic                  oeOff;
    logic                  asleep;
    logic                  interleave;
    logic                  selected;
    logic [ADDR_W-1:BW]    addrHigh;
    logic [BW-1:0]         burstStart;
    logic [BW-1:0]         burstBeat;
    pbsp_acc_t             accKind;
    logic                  accFirst;
    logic [ADDR_W-1:0]     accAddr;
    logic [LANES-1:0]      wrLanes;
    logic [WORD_W-1:0]     wrWord;
    logic [WORD_W-1:0]     outWord;
    logic                  outOe;
  } pbsp_state_t;

  pbsp_state_t st;
  pbsp_state_t next_st;

  // Array word: parity bits above the data bytes
  logic [WORD_W-1:0] mem [0:(2**ADDR_W)-1];

  logic pStrobe;
  logic cStrobe;
  logic load;
  logic enablesOk;
  logic writeAll;
  logic writeLanes;

  ////////////////////////////////////////////////////////////////////////////
  // Burst address: interleaved flips bits, linear adds and wraps
  function automatic logic [BW-1:0] burstLow(
    input logic [BW-1:0] start,
    input logic [BW-1:0] beat,
    input logic          interleave
  );
    if (interleave) begin
      return start ^ beat;
    end
    return BW'(start + beat);
  endfunction

  // Merge new lanes into a stored word; a lane is a byte and its parity
  function automatic logic [WORD_W-1:0] mergeWord(
    input logic [WORD_W-1:0] oldWord,
    input logic [WORD_W-1:0] newWord,
    input logic [LANES-1:0]  lanes
  );
    logic [WORD_W-1:0] w;
    w = oldWord;
    for (int i = 0; i < LANES; i++) begin
      if (lanes[i]) begin
        w[i*8 +: 8]    = newWord[i*8 +: 8];
        w[DATA_W + i]  = newWord[DATA_W + i];
      end
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strobe and select decode
  always_comb begin
    pStrobe    = !busCtrl.processorAddrStrobeN &&
                 !busCtrl.chipSelectPrimaryN;
    cStrobe    = !busCtrl.controllerAddrStrobeN && !pStrobe;
    load       = (pStrobe || cStrobe) && !st.asleep;
    enablesOk  = !busCtrl.chipSelectPrimaryN &&
                 busCtrl.chipSelectExpandHi &&
                 !busCtrl.chipSelectExpandN;
    writeAll   = !busCtrl.globalWriteN;
    writeLanes = !busCtrl.byteWriteEnableN &&
                 (~byteLaneSelectN != '0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;

    // Three-stage filters; a change counts once stages two and three agree
    next_st.oeSync    = {st.oeSync[1:0], outputEnableN};
    next_st.sleepSync = {st.sleepSync[1:0], sleepRequest};
    next_st.modeSync  = {st.modeSync[1:0], burstOrderMode};
    if (st.oeSync[1] == st.oeSync[2]) begin
      next_st.oeOff = st.oeSync[2];
    end
    if (st.sleepSync[1] == st.sleepSync[2]) begin
      next_st.asleep = st.sleepSync[2];
    end
    if (st.modeSync[1] == st.modeSync[2]) begin
      next_st.interleave = st.modeSync[2];
    end

    // Address capture and burst counting
    if (load) begin
      next_st.selected   = enablesOk;
      next_st.addrHigh   = address[ADDR_W-1:BW];
      next_st.burstStart = address[BW-1:0];
      next_st.burstBeat  = `PBSP_BEAT_RST;
    end else if (st.selected && !st.asleep &&
                 !busCtrl.burstAdvanceN) begin
      next_st.burstBeat = st.burstBeat + `PBSP_BEAT_STEP;
    end

    // First pipeline stage: access kind, address and write data
    next_st.accAddr  = {next_st.addrHigh,
                        burstLow(next_st.burstStart, next_st.burstBeat,
                                 st.interleave)};
    next_st.accFirst = load && !st.selected;
    next_st.wrWord   = {parityLanesIn, dataIn};
    next_st.wrLanes  = '0;
    if (st.asleep || !next_st.selected) begin
      next_st.accKind = PBSP_ACC_IDLE;
    end else if (writeAll) begin
      next_st.accKind = PBSP_ACC_WRITE;
      next_st.wrLanes = '1;
    end else if (writeLanes) begin
      next_st.accKind = PBSP_ACC_WRITE;
      next_st.wrLanes = ~byteLaneSelectN;
    end else begin
      next_st.accKind = PBSP_ACC_READ;
    end

    // Output stage; the pins stay inputs unless a read is showing
    if (st.accKind == PBSP_ACC_READ) begin
      next_st.outWord = mem[st.accAddr];
    end
    next_st.outOe = (st.accKind == PBSP_ACC_READ) && !st.accFirst &&
                    !st.oeOff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st            <= '0;
      st.oeSync     <= `PBSP_OE_SYNC_RST;
      st.sleepSync  <= `PBSP_SYNC_RST;
      st.modeSync   <= `PBSP_MODE_SYNC_RST;
      st.oeOff      <= `PBSP_OE_RST;
      st.asleep     <= `PBSP_SLEEP_RST;
      st.interleave <= `PBSP_MODE_RST;
      st.selected   <= `PBSP_SEL_RST;
      st.accKind    <= PBSP_ACC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Array write one edge after the controls; the array has no reset so
  // contents survive sleep, and a read right behind sees the new data
  always_ff @(posedge clk) begin
    if (st.accKind == PBSP_ACC_WRITE) begin
      mem[st.accAddr] <= mergeWord(mem[st.accAddr], st.wrWord,
                                   st.wrLanes);
    end
  end

  assign dataOut        = st.outWord[DATA_W-1:0];
  assign parityLanesOut = st.outWord[WORD_W-1:DATA_W];
  assign dataOe         = st.outOe;

endmodule

/* sim/pbsp_port_properties.sv */
// Port checker for the pipelined burst SRAM port
`timescale 1ns/1ns
module pbsp_port_properties
  import pbsp_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int LANES  = 4
)(
  // Watched ports
  input wire logic               clk,
  input wire logic               reset,
  input wire pbsp_ctrl_t         busCtrl,
  input wire logic [LANES-1:0]   byteLaneSelectN,
  input wire logic               outputEnableN,
  input wire logic [LANES*8-1:0] dataOut,
  input wire logic               dataOe
);
  wire ld = (!busCtrl.processorAddrStrobeN && !busCtrl.chipSelectPrimaryN)
    || !busCtrl.controllerAddrStrobeN;
  wire on = !busCtrl.chipSelectPrimaryN && busCtrl.chipSelectExpandHi
    && !busCtrl.chipSelectExpandN;
  wire ign = !busCtrl.processorAddrStrobeN && busCtrl.chipSelectPrimaryN
    && busCtrl.controllerAddrStrobeN;
  wire rd = busCtrl.globalWriteN && busCtrl.byteWriteEnableN;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  a_deselect_drops: assert property (ld && !on |-> ##2 !dataOe)
    else $error("driving after deselect");
  a_first_masked: assert property (
    ld && !on ##1 ld && on && rd |-> ##2 !dataOe)
    else $error("first read beat driven");
  a_oe_release: assert property (outputEnableN [*6] |-> !dataOe)
    else $error("driving with output enable off");
  a_global_quiet: assert property (!busCtrl.globalWriteN |-> ##2 !dataOe)
    else $error("driving on global write");
  a_lane_quiet: assert property (
    !busCtrl.byteWriteEnableN && !(&byteLaneSelectN) |-> ##2 !dataOe)
    else $error("driving on byte write");
  a_out_holds: assert property (ld && !on ##1 !ld |=> $stable(dataOut))
    else $error("read word changed while deselected");
  a_reset_idle: assert property ($fell(reset) |-> !dataOe)
    else $error("driving right after reset");
  a_strobe_ignored: assert property (
    (!outputEnableN && !ld) [*3]
    ##1 !outputEnableN && dataOe && ign && rd
    ##1 !outputEnableN |-> ##1 dataOe)
    else $error("ignored strobe deselected");
endmodule

bind pbsp_sram_port pbsp_port_properties #(.ADDR_W(ADDR_W), .LANES(LANES))
  pbsp_port_properties_i (.clk(clk), .reset(reset), .busCtrl(busCtrl),
  .byteLaneSelectN(byteLaneSelectN), .outputEnableN(outputEnableN),
  .dataOut(dataOut), .dataOe(dataOe));

/* sim/pbsp_host_model.sv */
// Host bus model driving controls and its half of the data pins
`timescale 1ns/1ns
module pbsp_host_model
  import pbsp_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Controls towards the device
  output pbsp_ctrl_t       busCtrl,
  output logic [18:0]      address,
  output logic [3:0]       byteLaneSelectN,
  output logic             outputEnableN,
  // Data pins, parity above data
  input  wire logic [35:0] devWord,
  input  wire logic        dataOe,
  output logic [35:0]      pinWord
);
  logic [35:0] hostWord = '0;
  logic        hostOe = 1'b0;
  logic [35:0] lastWord = '0;
  ////////////////////////////////////////////////////////////////////////
  // Released pins toggle, so a stale word never reads as valid
  assign pinWord = hostOe ? hostWord : dataOe ? devWord : ~lastWord;
  always @(posedge clk) lastWord <= pinWord;
  initial begin
    busCtrl = 8'hFA;
    address = '0;
    byteLaneSelectN = 4'hF;
    outputEnableN = 1'b0;
  end
  // Byte enable always travels with its lane selects
  task automatic put(input logic [7:0] c, input logic [18:0] a,
    input logic [3:0] bs, input logic [35:0] w);
    @(posedge clk);
    busCtrl <= c;
    address <= a;
    byteLaneSelectN <= bs;
    hostOe <= !(c[4] && c[3]);
    hostWord <= w;
    #1;
  endtask
endmodule

/* sim/pbsp_sram_port_bench.sv */
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/1ns
module pbsp_sram_port_bench;
  import pbsp_pkg::*;
  localparam logic [7:0] RLD = 8'hBA, RADV = 8'hDA, WLD = 8'hAA;
  localparam logic [7:0] WADV = 8'hCA, DES = 8'h38, BLD = 8'h72;
  localparam logic [7:0] IGN = 8'h7E, NOP = 8'hFA;
  logic clk = 1'b0;
  logic reset = 1'b1;
  int error_cnt = 0;
  int num_checks = 0;
  pbsp_ctrl_t busCtrl;
  logic [18:0] address;
  logic [3:0] byteLaneSelectN, parityLanesOut;
  logic outputEnableN, dataOe;
  logic sleepRequest = 1'b0;
  logic burstOrderMode = 1'b0;
  logic [35:0] pinWord;
  logic [31:0] dataOut;
  wire [35:0] devWord = {parityLanesOut, dataOut};
  pbsp_sram_port pbsp_sram_port_i (.clk(clk), .reset(reset),
    .busCtrl(busCtrl), .address(address), .byteLaneSelectN(byteLaneSelectN),
    .outputEnableN(outputEnableN), .sleepRequest(sleepRequest),
    .burstOrderMode(burstOrderMode), .dataIn(pinWord[31:0]),
    .parityLanesIn(pinWord[35:32]), .dataOut(dataOut),
    .parityLanesOut(parityLanesOut), .dataOe(dataOe));
  pbsp_host_model pbsp_host_model_i (.clk(clk), .busCtrl(busCtrl),
    .address(address), .byteLaneSelectN(byteLaneSelectN),
    .outputEnableN(outputEnableN), .devWord(devWord), .dataOe(dataOe),
    .pinWord(pinWord));
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  int k0 = 0;
  function automatic logic [35:0] wd(input int k);
    return {4'(k) ^ 4'h9, 32'h12345670 + 32'(k)};
  endfunction
  task automatic p(input logic [7:0] c, input logic [18:0] a = '0);
    pbsp_host_model_i.put(c, a, c[3] ? 4'h0 : 4'hA, c[4] ? '1 : wd(k0));
  endtask
  task automatic chk(input string n, input logic [35:0] e, g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Global burst write from beat 2, then linear read from beat 1
  task automatic t_burst;
    for (k0 = 0; k0 < 4; k0++) p(k0 == 0 ? WLD : WADV, 19'h00A32);
    p(DES);
    for (int k = 0; k < 6; k++) begin
      p(k == 0 ? RLD : k < 4 ? RADV : DES, 19'h00A31);
      if (k > 1) chk("beat", wd((k + 1) % 4), devWord);
      if (k > 1) chk("oe", 36'(k > 2), 36'(dataOe));
    end
    $display("burst done");
  endtask
  // Lanes 0 and 2 written; ignored strobe keeps the read going
  task automatic t_lanes;
    p(BLD, 19'h00A32);
    p(RLD, 19'h00A32);
    for (int k = 0; k < 6; k++) begin
      p(k == 3 ? IGN : NOP);
      if (k > 0) chk("lanes", 36'hD12FF56FF, devWord);
      if (k > 0) chk("oe", 36'h1, 36'(dataOe));
    end
    $display("lanes done");
  endtask
  task automatic t_release;
    p(DES);
    p(NOP);
    p(RLD, 19'h00A33);
    chk("deselect", 36'h0, 36'(dataOe));
    pbsp_host_model_i.outputEnableN <= 1'b1;
    repeat (6) p(NOP);
    chk("released", 36'h0, 36'(dataOe));
    pbsp_host_model_i.outputEnableN <= 1'b0;
    repeat (6) p(NOP);
    chk("redriven", wd(1), dataOe ? devWord : '0);
    $display("release done");
  endtask
  // Interleaved burst read from beat 1: lows 1, 0, 3, 2
  task automatic t_order;
    burstOrderMode <= 1'b1;
    repeat (6) p(NOP);
    p(DES);
    for (int k = 0; k < 6; k++) begin
      p(k == 0 ? RLD : k < 4 ? RADV : DES, 19'h00A31);
      if (k > 1) chk("order", k == 5 ? 36'hD12FF56FF : wd(5 - k), devWord);
    end
    $display("order done");
  endtask
  // Strobe ignored while asleep; contents kept through sleep
  task automatic t_sleep;
    sleepRequest <= 1'b1;
    repeat (5) p(NOP);
    p(RLD, 19'h00A33);
    repeat (3) p(NOP);
    chk("asleep", 36'h0, 36'(dataOe));
    sleepRequest <= 1'b0;
    repeat (5) p(NOP);
    p(RLD, 19'h00A33);
    repeat (3) p(NOP);
    chk("kept", wd(1), devWord);
    chk("woken", 36'h1, 36'(dataOe));
    $display("sleep done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    t_burst;
    t_lanes;
    t_release;
    t_order;
    t_sleep;
    conclude;
  end
  initial begin
    #20000;
    error_cnt++;
    conclude;
  end
endmodule
